/* File: core/tlb_ctrl.sv */
// Purpose: Arm, scan and measure layer sequencer with source bypass and skip command
// Assumes: APB slave at 125 MHz; six active-low open-drain trigger bus lines
// Notes:   Layer index 0 arm, 1 scan, 2 measure
`timescale 1ns/10ps
`include "tlb_regs.svh"
module tlb_ctrl #(
  parameter int PULSE_CYC = `TLB_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger bus, open drain
  input  wire logic [5:0]  tbus_in,
  output logic [5:0]       tbus_out,
  output logic [5:0]       tbus_oe,
  // External trigger input and completion output
  input  wire logic        ext_trig_in,
  output logic             measurement_complete_output,
  // Measurement action handshake
  output logic             meas_start,
  input  wire logic        meas_done
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin capture
  tlb_sync_if sif ();
  assign sif.raw     = tbus_in;
  assign sif.ext_raw = ext_trig_in;
  tlb_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic                 run_reg;
  logic                 prot_reg;
  tlb_pkg::tlb_src_t    src_reg   [3];
  logic [2:0]           byp_reg;
  logic [2:0]           iline_reg [3];
  logic [2:0]           oline_reg [3];
  logic [15:0]          cnt_reg   [3];
  logic [15:0]          dly_reg   [3];
  logic                 skip_err_reg;
  logic                 line_err_reg;

  function automatic logic [5:0] line_mask(input logic [2:0] ln);
    line_mask = (ln >= 3'h1 && ln <= 3'h6) ? 6'(6'h01 << (ln - 3'h1)) : 6'h00;
  endfunction

  function automatic logic [31:0] layer_off(input int idx, input logic [11:0] sub);
    layer_off = 32'(`TLB_LAYER0_OFF + `TLB_LAYER_STRIDE * idx + sub);
  endfunction

  wire        acc_set  = psel && !penable;
  wire        wr_take  = psel && penable && pwrite;
  wire        hit_ctrl = paddr == `TLB_CTRL_OFF;
  wire        hit_cmd  = paddr == `TLB_CMD_OFF;
  wire        hit_stat = paddr == `TLB_STAT_OFF;
  wire [2:0]  hit_cfg;
  wire [2:0]  hit_cnt;
  wire [2:0]  hit_dly;
  wire [2:0]  w_src    = pwdata[`TLB_CFG_SRC_LSB +: 3];
  wire [2:0]  w_iline  = pwdata[`TLB_CFG_ILINE_LSB +: 3];
  wire [2:0]  w_oline  = pwdata[`TLB_CFG_OLINE_LSB +: 3];
  wire        w_line_ok = (w_iline != w_oline) && line_mask(w_iline) != 6'h00 && line_mask(w_oline) != 6'h00;
  wire        w_src_ok  = w_src <= 3'h5;
  wire        cmd_wr    = wr_take && hit_cmd;
  wire [2:0]  skip_req  = cmd_wr ? pwdata[`TLB_CMD_SKIP_LSB +: 3] : 3'h0;
  wire        preset    = cmd_wr && pwdata[`TLB_CMD_PRESET_BIT];
  wire        err_clr   = cmd_wr && pwdata[`TLB_CMD_ERRCLR_BIT];
  wire        any_hit   = hit_ctrl | hit_cmd | hit_stat | (|hit_cfg) | (|hit_cnt) | (|hit_dly);

  for (genvar g = 0; g < 3; g++) begin : g_dec
    assign hit_cfg[g] = {20'h00000, paddr} == layer_off(g, `TLB_CFG_SUB);
    assign hit_cnt[g] = {20'h00000, paddr} == layer_off(g, `TLB_CNT_SUB);
    assign hit_dly[g] = {20'h00000, paddr} == layer_off(g, `TLB_DLY_SUB);
  end

  // Measure layer in shared mode skips the line check; arm and scan are always split
  function automatic logic cfg_legal(input int idx, input logic shared, input logic ok, input logic srcok);
    cfg_legal = srcok && ((idx == 2 && shared) || ok);
  endfunction

  wire [2:0] cfg_bad;
  for (genvar g = 0; g < 3; g++) begin : g_bad
    assign cfg_bad[g] = wr_take && hit_cfg[g] && !cfg_legal(g, prot_reg, w_line_ok, w_src_ok);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg  <= 1'b0;
      prot_reg <= 1'b0;
      byp_reg  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        src_reg[i]   <= tlb_pkg::TLB_SRC_IMM;
        iline_reg[i] <= `TLB_ILINE_RST;
        oline_reg[i] <= `TLB_OLINE_RST;
        cnt_reg[i]   <= `TLB_CNT_RST;
        dly_reg[i]   <= 16'h0000;
      end
    end else if (preset) begin
      run_reg  <= 1'b0;
      prot_reg <= 1'b0;
      byp_reg  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        src_reg[i]   <= tlb_pkg::TLB_SRC_IMM;
        iline_reg[i] <= `TLB_ILINE_RST;
        oline_reg[i] <= `TLB_OLINE_RST;
        cnt_reg[i]   <= `TLB_CNT_RST;
        dly_reg[i]   <= 16'h0000;
      end
    end else if (wr_take) begin
      if (hit_ctrl) begin
        run_reg  <= pwdata[`TLB_CTRL_RUN_BIT];
        prot_reg <= pwdata[`TLB_CTRL_PROT_BIT];
      end
      for (int i = 0; i < 3; i++) begin
        if (hit_cfg[i] && !cfg_bad[i]) begin
          src_reg[i]   <= tlb_pkg::tlb_src_t'(w_src);
          byp_reg[i]   <= pwdata[`TLB_CFG_BYP_BIT];
          iline_reg[i] <= w_iline;
          oline_reg[i] <= w_oline;
        end
        if (hit_cnt[i]) cnt_reg[i] <= pwdata[15:0];
        if (hit_dly[i]) dly_reg[i] <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  tlb_pkg::tlb_state_t st_reg;
  logic [1:0]          lay_reg;
  logic [15:0]         pass_reg  [3];
  logic [2:0]          first_reg;
  logic [15:0]         wait_reg;
  logic [15:0]         tim_reg;
  logic [2:0]          fire_reg;
  logic                meas_fire_reg;

  wire [5:0]  rise   = sif.rise;
  wire [2:0]  arrive;
  wire [2:0]  waiting;
  wire [2:0]  bypass_now;
  for (genvar g = 0; g < 3; g++) begin : g_evt
    // Shared mode on the measure layer listens on the output line itself
    wire [2:0] in_line = (g == 2 && prot_reg) ? oline_reg[g] : iline_reg[g];
    assign arrive[g] = (src_reg[g] == tlb_pkg::TLB_SRC_IMM) ||
                       (src_reg[g] == tlb_pkg::TLB_SRC_BUS && (rise & line_mask(in_line)) != 6'h00) ||
                       (src_reg[g] == tlb_pkg::TLB_SRC_EXT && sif.ext_rise) ||
                       (src_reg[g] == tlb_pkg::TLB_SRC_TIM && g != 0 && tim_reg == 16'h0000);
    assign waiting[g]    = st_reg == tlb_pkg::TLB_SRC && lay_reg == 2'(g);
    assign bypass_now[g] = byp_reg[g] && first_reg[g] &&
                           (src_reg[g] == tlb_pkg::TLB_SRC_EXT || src_reg[g] == tlb_pkg::TLB_SRC_BUS);
  end

  wire [2:0] skip_bad = skip_req & ~waiting;
  wire       lay_go   = arrive[lay_reg] || skip_req[lay_reg];
  wire       lay_done = pass_reg[lay_reg] + 16'h0001 >= cnt_reg[lay_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= tlb_pkg::TLB_IDLE;
      lay_reg       <= 2'h0;
      first_reg     <= 3'h7;
      wait_reg      <= 16'h0000;
      tim_reg       <= 16'h0000;
      fire_reg      <= 3'h0;
      meas_fire_reg <= 1'b0;
      meas_start    <= 1'b0;
      for (int i = 0; i < 3; i++) pass_reg[i] <= 16'h0000;
    end else begin
      fire_reg      <= 3'h0;
      meas_fire_reg <= 1'b0;
      meas_start    <= 1'b0;
      tim_reg       <= tim_reg != 16'h0000 ? tim_reg - 16'h0001 : dly_reg[lay_reg];
      unique case (st_reg)
        tlb_pkg::TLB_IDLE: begin
          first_reg <= 3'h7;
          lay_reg   <= 2'h0;
          if (run_reg) st_reg <= tlb_pkg::TLB_SRC;
        end
        tlb_pkg::TLB_SRC: begin
          if (bypass_now[lay_reg]) begin
            first_reg[lay_reg] <= 1'b0;
            wait_reg           <= 16'h0000;
            st_reg             <= lay_reg == 2'h0 ? tlb_pkg::TLB_ACT : tlb_pkg::TLB_DLY;
          end else if (lay_go) begin
            first_reg[lay_reg] <= 1'b0;
            wait_reg           <= lay_reg == 2'h0 ? 16'h0000 : dly_reg[lay_reg];
            st_reg             <= tlb_pkg::TLB_DLY;
          end
        end
        tlb_pkg::TLB_DLY: begin
          if (wait_reg != 16'h0000) begin
            wait_reg <= wait_reg - 16'h0001;
          end else begin
            st_reg <= tlb_pkg::TLB_ACT;
          end
        end
        tlb_pkg::TLB_ACT: begin
          if (lay_reg != 2'h2) begin
            // Descend into the enclosed layer, which starts a fresh first pass
            fire_reg[lay_reg] <= byp_reg[lay_reg];
            first_reg[lay_reg + 2'h1] <= 1'b1;
            pass_reg[lay_reg + 2'h1]  <= 16'h0000;
            lay_reg  <= lay_reg + 2'h1;
            st_reg   <= tlb_pkg::TLB_SRC;
          end else begin
            // Drop the request on the edge that takes done, so one action is asked once
            meas_start <= !meas_done;
            if (meas_done) begin
              meas_fire_reg <= 1'b1;
              st_reg        <= tlb_pkg::TLB_EXIT;
            end
          end
        end
        tlb_pkg::TLB_EXIT: begin
          if (!lay_done) begin
            pass_reg[lay_reg] <= pass_reg[lay_reg] + 16'h0001;
            st_reg            <= tlb_pkg::TLB_SRC;
          end else if (lay_reg == 2'h0) begin
            st_reg <= tlb_pkg::TLB_IDLE;
          end else begin
            lay_reg <= lay_reg - 2'h1;
          end
        end
      endcase
      if (!run_reg) st_reg <= tlb_pkg::TLB_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing
  logic [2:0] lay_pulse;
  for (genvar g = 0; g < 3; g++) begin : g_pulse
    tlb_pulse #(.WIDTH(PULSE_CYC)) u_pulse (
      .pclk    (pclk),
      .presetn (presetn),
      .fire    (g == 2 ? meas_fire_reg : fire_reg[g]),
      .pulse   (lay_pulse[g])
    );
  end

  logic [5:0] drive;
  logic       comp;
  always_comb begin
    drive = 6'h00;
    comp  = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (src_reg[i] == tlb_pkg::TLB_SRC_BUS) drive = drive | (lay_pulse[i] ? line_mask(oline_reg[i]) : 6'h00);
      else comp = comp | lay_pulse[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbus_out                    <= 6'h00;
      tbus_oe                     <= 6'h00;
      measurement_complete_output <= 1'b0;
      skip_err_reg                <= 1'b0;
      line_err_reg                <= 1'b0;
    end else begin
      tbus_out                    <= 6'h00;
      tbus_oe                     <= drive;
      measurement_complete_output <= comp;
      skip_err_reg                <= (|skip_bad) || (skip_err_reg && !err_clr);
      line_err_reg                <= (|cfg_bad) || (line_err_reg && !err_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and answer; always zero wait states
  logic [31:0] rd;
  always_comb begin
    rd = 32'h00000000;
    if (hit_ctrl) rd = {30'h0, prot_reg, run_reg};
    if (hit_stat) rd = {8'h00, (byp_reg[2] ? `TLB_TOK_BYP_ON : `TLB_TOK_BYP_OFF),
                        (prot_reg ? `TLB_TOK_SHARED : `TLB_TOK_SPLIT),
                        2'h0, line_err_reg, skip_err_reg, 1'b0, 3'(st_reg)};
    for (int i = 0; i < 3; i++) begin
      if (hit_cfg[i]) rd = {17'h0, oline_reg[i], 1'b0, iline_reg[i], 3'h0, byp_reg[i], 1'b0, 3'(src_reg[i])};
      if (hit_cnt[i]) rd = {16'h0, cnt_reg[i]};
      if (hit_dly[i]) rd = {16'h0, dly_reg[i]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_set;
      pslverr <= acc_set && (!any_hit || (pwrite && |hit_cfg && !cfg_legal(32'(paddr[5:4]) - 1, prot_reg, w_line_ok, w_src_ok)));
      if (acc_set) prdata <= rd;
    end
  end
endmodule // tlb_ctrl

/* File: core/tlb_regs.svh */
// Purpose: Offsets, fields, reset values and timing counts for the trigger layer bypass control block
// Assumes: APB with 32-bit data, 125 MHz pclk
// Notes:   Included by the tlb_ctrl and tlb_pulse design files of the block
`ifndef TLB_REGS_SVH
`define TLB_REGS_SVH

// Register byte offsets
`define TLB_CTRL_OFF        12'h000
`define TLB_CMD_OFF         12'h004
`define TLB_STAT_OFF        12'h008
`define TLB_LAYER0_OFF      12'h010
`define TLB_LAYER_STRIDE    12'h010
`define TLB_CFG_SUB         12'h000
`define TLB_CNT_SUB         12'h004
`define TLB_DLY_SUB         12'h008

// CTRL fields
`define TLB_CTRL_RUN_BIT    0
`define TLB_CTRL_PROT_BIT   1
// CMD fields (write only, self clearing)
`define TLB_CMD_SKIP_LSB    0
`define TLB_CMD_PRESET_BIT  4
`define TLB_CMD_ERRCLR_BIT  5
`define TLB_CMD_MEAS_DONE   6
// Layer CFG fields
`define TLB_CFG_SRC_LSB     0
`define TLB_CFG_BYP_BIT     4
`define TLB_CFG_ILINE_LSB   8
`define TLB_CFG_OLINE_LSB   12
// STAT fields
`define TLB_STAT_STATE_LSB  0
`define TLB_STAT_SKIPERR    4
`define TLB_STAT_LINEERR    5
`define TLB_STAT_PROTTOK    8
`define TLB_STAT_BYPTOK     16

// Readback tokens
`define TLB_TOK_SPLIT       8'h41
`define TLB_TOK_SHARED      8'h53
`define TLB_TOK_BYP_ON      8'h53
`define TLB_TOK_BYP_OFF     8'h41

// Reset values
`define TLB_ILINE_RST       3'h2
`define TLB_OLINE_RST       3'h1
`define TLB_CNT_RST         16'h0001

// Output pulse width
`define TLB_PULSE_NS        1000
`define TLB_CLK_MHZ         125
`define TLB_PULSE_CYC       ((`TLB_PULSE_NS * `TLB_CLK_MHZ + 999) / 1000)

`endif

/* File: core/tlb_pkg.sv */
// Purpose: Types of the trigger layer bypass control block
// Assumes: Nothing
// Notes:   Constants live in tlb_regs.svh
package tlb_pkg;
  typedef enum logic [2:0] {
    TLB_SRC_IMM, TLB_SRC_EXT, TLB_SRC_BUS, TLB_SRC_MAN, TLB_SRC_HOST, TLB_SRC_TIM
  } tlb_src_t;

  typedef enum {
    TLB_IDLE, TLB_SRC, TLB_DLY, TLB_ACT, TLB_EXIT
  } tlb_state_t;
endpackage

/* File: core/tlb_sync_if.sv */
// Purpose: Carrier between the top and its pin helpers
// Assumes: One clock
// Notes:   Six trigger bus lines
`timescale 1ns/10ps
interface tlb_sync_if;
  logic [5:0] raw;
  logic [5:0] rise;
  logic       ext_raw;
  logic       ext_rise;
  modport pins (input raw, input ext_raw, output rise, output ext_rise);
  modport core (output raw, output ext_raw, input rise, input ext_rise);
endinterface // tlb_sync_if

/* File: core/tlb_pin_sync.sv */
// Purpose: Three-stage capture of the bus lines and the external trigger
// Assumes: Inputs are asynchronous to pclk
// Notes:   Edge counts when stages two and three agree; stage one feeds only stage two
`timescale 1ns/10ps
module tlb_pin_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Carrier
  tlb_sync_if.pins  sif
);
  logic [6:0] s1_reg;
  logic [6:0] s2_reg;
  logic [6:0] s3_reg;
  logic [6:0] lvl_reg;
  logic [6:0] agree;
  logic [6:0] lvl_next;

  assign agree    = ~(s2_reg ^ s3_reg);
  assign lvl_next = (agree & s3_reg) | (~agree & lvl_reg);
  // Bus lines are active low, so a fall of the line is an incoming trigger
  assign sif.rise     = lvl_reg[5:0] & ~lvl_next[5:0];
  assign sif.ext_rise = lvl_next[6] & ~lvl_reg[6];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= 7'h3f;
      s2_reg  <= 7'h3f;
      s3_reg  <= 7'h3f;
      lvl_reg <= 7'h3f;
    end else begin
      s1_reg  <= {sif.ext_raw, sif.raw};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end
endmodule // tlb_pin_sync

/* File: core/tlb_pulse.sv */
// Purpose: Stretches a one-cycle fire request into a fixed-width pulse
// Assumes: Requests closer than the width merge
// Notes:   Output is a register
`timescale 1ns/10ps
`include "tlb_regs.svh"
module tlb_pulse #(
  parameter int WIDTH = `TLB_PULSE_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and pulse
  input  wire logic fire,
  output logic      pulse
);
  logic [15:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      pulse   <= 1'b0;
    end else begin
      cnt_reg <= fire ? 16'(WIDTH) : (cnt_reg != 16'h0000 ? cnt_reg - 16'h0001 : 16'h0000);
      pulse   <= fire || cnt_reg > 16'h0001;
    end
  end
endmodule // tlb_pulse

/* File: sim/tlb_ctrl_chk.sv */
// Purpose: Port-level assertions for tlb_ctrl
// Assumes: One clock domain, bound to tlb_ctrl
// Notes:   Token helpers follow accepted APB writes only
`timescale 1ns/10ps
module tlb_ctrl_chk #(
  parameter int PULSE_CYC = 2
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic [5:0]  tbus_out,
  input wire logic [5:0]  tbus_oe,
  input wire logic        measurement_complete_output,
  input wire logic        meas_start,
  input wire logic        meas_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hi_cnt_reg;
  logic       prot_reg;
  logic       byp_reg;
  ////////////////////////////////////////
  // Mirror of settings so token readback can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= 1'b0;
      byp_reg  <= 1'b0;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == 12'h004 && pwdata[4]) begin
        prot_reg <= 1'b0;
        byp_reg  <= 1'b0;
      end
      if (paddr == 12'h000)
        prot_reg <= pwdata[1];
      if (paddr == 12'h030)
        byp_reg <= pwdata[4];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_cnt_reg <= 8'h00;
    else
      hi_cnt_reg <= measurement_complete_output ? hi_cnt_reg + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  sequence stat_rd_s; access_s ##0 (!pwrite && paddr == 12'h008); endsequence
  sequence act_end_s; meas_done && meas_start; endsequence
  chk_ready_next: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_bad_addr: assert property (access_s ##0 (paddr == 12'h00c) |-> pslverr)
    else $error("unmapped access not refused");
  chk_line_clash: assert property (access_s ##0 (pwrite && (paddr == 12'h010 || paddr == 12'h020)
    && pwdata[10:8] == pwdata[14:12]) |-> pslverr) else $error("equal lines accepted");
  chk_prot_token: assert property (stat_rd_s |-> prdata[15:8] == (prot_reg ? 8'h53 : 8'h41))
    else $error("protocol token wrong");
  chk_byp_token: assert property (stat_rd_s |-> prdata[23:16] == (byp_reg ? 8'h53 : 8'h41))
    else $error("bypass token wrong");
  chk_done_pulse: assert property (act_end_s |-> ##[1:8] (measurement_complete_output || (|tbus_oe)))
    else $error("no output pulse after action");
  chk_action_ends: assert property (act_end_s |=> !meas_start)
    else $error("action not ended by done");
  chk_pulse_width: assert property ($fell(measurement_complete_output) |-> hi_cnt_reg == 8'(PULSE_CYC))
    else $error("completion pulse width wrong");
  chk_open_drain: assert property (tbus_out == 6'h00)
    else $error("bus line driven high");
endmodule // tlb_ctrl_chk

bind tlb_ctrl tlb_ctrl_chk #(.PULSE_CYC(PULSE_CYC)) i_tlb_ctrl_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .tbus_out, .tbus_oe, .measurement_complete_output, .meas_start,
  .meas_done);

/* File: sim/tlb_bus_peer.sv */
// Purpose: Other instruments on the trigger bus plus the measurement action
// Assumes: Lines are open drain with pull-ups
// Notes:   lat sets how slowly the action completes
`timescale 1ns/10ps
module tlb_bus_peer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Trigger bus
  input  wire logic [5:0] tbus_oe,
  input  wire logic [5:0] pull,
  output logic [5:0]      tbus_in,
  // Measurement action
  input  wire logic [3:0] lat,
  input  wire logic       meas_start,
  output logic            meas_done
);
  logic [3:0] wait_reg;
  logic       served_reg;
  // Any party pulling a line wins; a released line floats high
  assign tbus_in = ~(tbus_oe | pull);
  // One done per action, so a slow drop of meas_start is not answered twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg   <= 4'h0;
      served_reg <= 1'b0;
      meas_done  <= 1'b0;
    end else begin
      meas_done  <= meas_start && !served_reg && wait_reg == lat;
      served_reg <= meas_start && (served_reg || wait_reg == lat);
      wait_reg   <= (meas_start && !served_reg && wait_reg != lat) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule // tlb_bus_peer

/* File: sim/tlb_ctrl_tb.sv */
// Purpose: Self-checking bench for tlb_ctrl
// Assumes: Pulse width shortened to 2 cycles
// Notes:   Only the external trigger input is tied
`timescale 1ns/10ps
module tlb_ctrl_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  tbus_in;
  logic [5:0]  tbus_oe;
  logic [5:0]  pull = 6'h00;
  logic [3:0]  lat = 4'h0;
  logic        ext_trig_in = 1'b0;
  logic        mco;
  logic        meas_start;
  logic        meas_done;
  logic [31:0] q;
  logic        e;
  logic        seen;
  int          errors = 0;
  int          checked = 0;
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, x); end end
  always #4 pclk = ~pclk;
  tlb_ctrl #(.PULSE_CYC(2)) i_tlb_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tbus_in, .tbus_out(), .tbus_oe, .ext_trig_in, .measurement_complete_output(mco),
    .meas_start, .meas_done);
  tlb_bus_peer i_peer (.pclk, .presetn, .tbus_oe, .pull, .tbus_in, .lat, .meas_start, .meas_done);
  ////////////////////////////////////////
  task automatic end_of_test;
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at the answer mid-cycle, where it stands settled until the next rising edge
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) errors++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
    xfer(a, 1'b1, d);
    `CHK(e, x)
  endtask
  // Watches a fixed window: serves both must-happen and must-not-happen checks
  task automatic watch(input int s);
    seen = 1'b0;
    repeat (60) begin
      @(posedge pclk);
      if ((s == 0 && meas_start) || (s == 1 && tbus_oe[0]) || (s == 2 && mco)) seen = 1'b1;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      xfer(12'h010 + 12'(16 * i), 1'b0, 32'h0);
      `CHK(q[14:0], 15'h1200)
      xfer(12'h014 + 12'(16 * i), 1'b0, 32'h0);
      `CHK(q[15:0], 16'h0001)
    end
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[23:8], 16'h4141)
    wr(12'h000, 32'h2, 1'b0);
    wr(12'h030, 32'h1110, 1'b0);
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[23:8], 16'h5353)
    wr(12'h010, 32'h1100, 1'b1);
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[5], 1'b1)
    wr(12'h004, 32'h10, 1'b0);
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[23:8], 16'h4141)
    wr(12'h030, 32'h1100, 1'b1);
    wr(12'h004, 32'h20, 1'b0);
    wr(12'h004, 32'h1, 1'b0);
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[5:4], 2'b01)
    xfer(12'h00c, 1'b0, 32'h0);
    `CHK(e, 1'b1)
    // Arm waits on the tied external input until skipped
    wr(12'h004, 32'h20, 1'b0);
    wr(12'h010, 32'h1201, 1'b0);
    wr(12'h000, 32'h1, 1'b0);
    watch(0);
    `CHK(seen, 1'b0)
    wr(12'h004, 32'h1, 1'b0);
    watch(2);
    `CHK(seen, 1'b1)
    watch(0);
    `CHK(seen, 1'b0)
    xfer(12'h008, 1'b0, 32'h0);
    `CHK(q[4], 1'b0)
    wr(12'h000, 32'h0, 1'b0);
    // Bus source with bypass: no input needed, pulse on output line 1
    wr(12'h010, 32'h1212, 1'b0);
    wr(12'h000, 32'h1, 1'b0);
    watch(1);
    `CHK(seen, 1'b1)
    watch(1);
    `CHK(seen, 1'b1)
    wr(12'h000, 32'h0, 1'b0);
    // Bus source without bypass, slow action
    lat <= 4'h9;
    wr(12'h010, 32'h1202, 1'b0);
    wr(12'h000, 32'h1, 1'b0);
    watch(0);
    `CHK(seen, 1'b0)
    pull <= 6'h02;
    watch(2);
    `CHK(seen, 1'b1)
    watch(1);
    `CHK(seen, 1'b0)
    pull <= 6'h00;
    wr(12'h000, 32'h0, 1'b0);
    end_of_test;
  end
  initial begin
    #100us;
    errors++;
    end_of_test;
  end
endmodule // tlb_ctrl_tb
